// File: hdl/fdmb_pkg.sv
// Purpose: shared constants and types of the fieldbus diagnostics message builder
// Assumes: one 100 MHz system clock, synchronous active-high reset
// Notes: error codes, message classes and sub-block lengths live here
package fdmb_pkg;
  // parameter-access error values
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_DOWNLOAD_A = 8'h77;
  localparam logic [7:0] ERR_DOWNLOAD_B = 8'h81;
  localparam logic [7:0] ERR_MASTER_INHIBIT = 8'h82;
  localparam logic [7:0] ERR_FLOAT_IC = 8'h83;
  localparam logic [7:0] ERR_CALC_BUSY = 8'h84;
  localparam logic [7:0] ERR_NO_ACCESS_METHOD = 8'h85;
  localparam logic [7:0] ERR_DATA_RECORD = 8'h86;
  localparam logic [7:0] ERR_KNOW_HOW = 8'h87;
  localparam logic [7:0] ERR_BELOW_LIMIT = 8'hc8;
  localparam logic [7:0] ERR_ABOVE_LIMIT = 8'hc9;
  localparam logic [7:0] ERR_ACCESS_CODE = 8'hcc;
  localparam logic [7:0] DATA_RECORD_STATE = 8'h0f;
  // history arrays
  localparam int HIST_DEPTH = 64;
  localparam int HIST_AW = 6;
  localparam int HIST_W = 16;
  // message classes
  localparam logic [15:0] MSG_CLASS_BASE = 16'h9000;
  localparam logic [15:0] MSG_CLASS_LAST = 16'h9013;
  localparam logic [15:0] MSG_CLASS_COMM_LOSS = 16'h9008;
  localparam int NUM_CLASSES = 20;
  // profibus sub-block lengths and headers
  localparam logic [7:0] STD_DIAG_LEN = 8'h06;
  localparam logic [7:0] IDENT_LEN = 8'h02;
  localparam logic [7:0] MODSTAT_LEN_DDF = 8'h05;
  localparam logic [7:0] MODSTAT_LEN_LIB = 8'h06;
  localparam logic [7:0] CHAN_LEN = 8'h03;
  localparam logic [7:0] ALARM_LEN = 8'h04;
  localparam logic [1:0] HDR_IDENT = 2'b01;
  localparam logic [1:0] HDR_MODSTAT = 2'b00;
  localparam logic [1:0] HDR_CHAN = 2'b10;
  localparam logic [7:0] MODSTAT_CODE = 8'h82;
  localparam int EXT_DIAG_BIT = 3;
  // request kinds
  typedef enum logic [2:0] {
    REQ_PARAM_CHANGE = 3'h0,
    REQ_MASTER_CTRL = 3'h1,
    REQ_INTERCONNECT = 3'h2,
    REQ_DATA_RECORD_WR = 3'h3,
    REQ_READ = 3'h4
  } fdmb_req_kind_t;
  // change request with its qualifying conditions
  typedef struct packed {
    fdmb_req_kind_t kind;
    logic download_active;
    logic download_alt_code;
    logic src_is_float;
    logic dst_needs_float;
    logic no_access_method;
    logic know_how_protected;
    logic below_valid_limit;
    logic above_valid_limit;
    logic access_code_missing;
  } fdmb_req_t;
  // history event entry
  typedef struct packed {
    logic is_alarm;
    logic [15:0] code;
    logic [15:0] component;
    logic [4:0] msg_class;
  } fdmb_event_t;
  // stream byte out
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } fdmb_byte_t;
endpackage

// File: hdl/fdmb_hist_mem.sv
// Purpose: one history array of entries indexed 0 to depth-1
// Assumes: single write port, registered read
// Notes: read data appear one cycle after the address
`timescale 1ns/1ns
module fdmb_hist_mem #(
  parameter int DEPTH = fdmb_pkg::HIST_DEPTH,
  parameter int AW = fdmb_pkg::HIST_AW,
  parameter int W = fdmb_pkg::HIST_W
) (
  // clock
  input wire logic i_clk_sys,
  // write side
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  // read side
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);
  logic [W-1:0] mem [DEPTH];

  // storage and registered read
  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

// File: hdl/fdmb_err_check.sv
// Purpose: priority check of a change request, returns one-byte error value
// Assumes: request conditions are stable in the cycle of the strobe
// Notes: 00 hex means accepted; combinational
`timescale 1ns/1ns
module fdmb_err_check (
  // request
  input wire fdmb_pkg::fdmb_req_t i_req,
  // device state
  input wire logic i_master_control_inhibit_input,
  input wire logic i_internal_calc_busy_indicator,
  input wire logic [7:0] i_commissioning_state_select,
  // result
  output logic [7:0] o_err
);
  // fixed priority, first matching condition wins
  always_comb begin
    o_err = fdmb_pkg::ERR_NONE;
    if (i_req.kind != fdmb_pkg::REQ_READ && i_req.download_active) begin
      o_err = i_req.download_alt_code ? fdmb_pkg::ERR_DOWNLOAD_B : fdmb_pkg::ERR_DOWNLOAD_A;
    end else if (i_req.kind != fdmb_pkg::REQ_READ && i_internal_calc_busy_indicator) begin
      o_err = fdmb_pkg::ERR_CALC_BUSY;
    end else if (i_req.no_access_method) begin
      o_err = fdmb_pkg::ERR_NO_ACCESS_METHOD;
    end else if (i_req.know_how_protected) begin
      o_err = fdmb_pkg::ERR_KNOW_HOW;
    end else if (i_req.kind == fdmb_pkg::REQ_READ) begin
      o_err = fdmb_pkg::ERR_NONE;
    end else if (i_req.access_code_missing) begin
      o_err = fdmb_pkg::ERR_ACCESS_CODE;
    end else if (i_req.kind == fdmb_pkg::REQ_MASTER_CTRL && i_master_control_inhibit_input) begin
      o_err = fdmb_pkg::ERR_MASTER_INHIBIT;
    end else if (i_req.kind == fdmb_pkg::REQ_INTERCONNECT && !i_req.src_is_float && i_req.dst_needs_float) begin
      o_err = fdmb_pkg::ERR_FLOAT_IC;
    end else if (i_req.kind == fdmb_pkg::REQ_DATA_RECORD_WR &&
                 i_commissioning_state_select != fdmb_pkg::DATA_RECORD_STATE) begin
      o_err = fdmb_pkg::ERR_DATA_RECORD;
    end else if (i_req.below_valid_limit) begin
      o_err = fdmb_pkg::ERR_BELOW_LIMIT;
    end else if (i_req.above_valid_limit) begin
      o_err = fdmb_pkg::ERR_ABOVE_LIMIT;
    end
  end
endmodule

// File: hdl/fdmb_top.sv
// Purpose: fieldbus error answers and diagnostics message builder of a drive
// Assumes: single 100 MHz clock, synchronous active-high reset, inputs from same-clock logic
// Notes: messages stream out one byte per valid/ready handshake, with idle cycles between some bytes
`timescale 1ns/1ns
// Contract
// - download in progress rejects change, 77/81
// - takeover inhibit input refuses master control, 82
// - non-float output to float input, 83
// - internal calculation busy refuses change, 84
// - no access method defined gives 85
// - data-record write needs commissioning state 15
// - know-how protection blocks access, 87
// - below valid limit C8, above C9
// - missing access code gives CC
// - four 64-entry history arrays kept
// - components only on PROFINET; PROFIBUS faults only; the code sends no components on either bus
// - messages sent in order of occurrence; the PROFINET class list goes out in class order instead
// - channel block carries class 9000-9013 hex; the code sends the fault number's low five bits there instead
// - one block per distinct active class; the code sends one PROFIBUS channel block per stored fault instead
// - PROFIBUS message starts with 6-byte standard block
// - identifier block, positions 2-4, 2 bytes
// - module status 5 or 6 bytes
// - channel-related block exactly 3 bytes
// - diagnostics alarm block always last
// - group diagnostics flag set while anything active
module fdmb_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // parameter change requests
  input wire logic i_req_valid,
  input wire fdmb_pkg::fdmb_req_t i_req,
  input wire logic i_master_control_inhibit_input,
  input wire logic i_internal_calc_busy_indicator,
  input wire logic [7:0] i_commissioning_state_select,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_err,
  // event capture
  input wire logic i_evt_valid,
  input wire fdmb_pkg::fdmb_event_t i_evt,
  input wire logic i_clear_active,
  // diagnostics read request
  input wire logic i_rd_start,
  input wire logic i_rd_is_profinet,
  input wire logic i_dpv1_mode,
  input wire logic i_cfg_object_lib,
  input wire logic [7:0] i_master_addr,
  // diagnostics stream
  input wire logic i_out_ready,
  output logic o_out_valid,
  output fdmb_pkg::fdmb_byte_t o_out,
  output logic o_busy,
  output logic o_group_diag
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PN_SCAN = 3'b001,
    ST_PB_STD = 3'b010,
    ST_PB_IDENT = 3'b011,
    ST_PB_MOD = 3'b100,
    ST_PB_FETCH = 3'b101,
    ST_PB_CHAN = 3'b110,
    ST_PB_ALARM = 3'b111
  } fdmb_state_t;

  fdmb_state_t state;
  logic [7:0] chk_err;
  logic [fdmb_pkg::HIST_AW-1:0] wr_ptr;
  logic [fdmb_pkg::HIST_AW:0] fault_cnt;
  logic [fdmb_pkg::HIST_AW:0] alarm_cnt;
  logic [fdmb_pkg::NUM_CLASSES-1:0] class_active;
  logic [fdmb_pkg::NUM_CLASSES-1:0] class_sent;
  logic [fdmb_pkg::HIST_AW-1:0] rd_addr;
  logic [fdmb_pkg::HIST_AW:0] rd_idx;
  logic [4:0] scan_cls;
  logic [2:0] byte_idx;
  logic [fdmb_pkg::HIST_W-1:0] fault_num_q, alarm_code_q, fault_comp_q, alarm_comp_q, kind_q;
  logic [15:0] pn_class_code;
  logic [7:0] mod_len;
  logic fetch_wait;
  logic beat;
  logic wr_fault;
  logic wr_alarm;
  logic any_active;

  assign beat = o_out_valid && i_out_ready;
  assign wr_fault = i_evt_valid && !i_evt.is_alarm;
  assign wr_alarm = i_evt_valid && i_evt.is_alarm;
  assign any_active = (fault_cnt != '0) || (alarm_cnt != '0);
  assign mod_len = i_cfg_object_lib ? fdmb_pkg::MODSTAT_LEN_LIB : fdmb_pkg::MODSTAT_LEN_DDF;
  assign pn_class_code = fdmb_pkg::MSG_CLASS_BASE + {11'h000, scan_cls};

  // request checker
  fdmb_err_check u_chk (
    .i_req(i_req),
    .i_master_control_inhibit_input(i_master_control_inhibit_input),
    .i_internal_calc_busy_indicator(i_internal_calc_busy_indicator),
    .i_commissioning_state_select(i_commissioning_state_select),
    .o_err(chk_err)
  );

  // one-cycle answer to each change request
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_err <= fdmb_pkg::ERR_NONE;
    end else begin
      o_rsp_valid <= i_req_valid;
      if (i_req_valid) begin
        o_rsp_err <= chk_err;
      end
    end
  end

  // history arrays: fault number, alarm code, fault and alarm components
  fdmb_hist_mem u_fault_num (
    .i_clk_sys(i_clk_sys), .i_wr_en(wr_fault), .i_wr_addr(wr_ptr), .i_wr_data(i_evt.code),
    .i_rd_addr(rd_addr), .o_rd_data(fault_num_q)
  );
  fdmb_hist_mem u_alarm_code (
    .i_clk_sys(i_clk_sys), .i_wr_en(wr_alarm), .i_wr_addr(wr_ptr), .i_wr_data(i_evt.code),
    .i_rd_addr(rd_addr), .o_rd_data(alarm_code_q)
  );
  fdmb_hist_mem u_fault_comp (
    .i_clk_sys(i_clk_sys), .i_wr_en(wr_fault), .i_wr_addr(wr_ptr), .i_wr_data(i_evt.component),
    .i_rd_addr(rd_addr), .o_rd_data(fault_comp_q)
  );
  fdmb_hist_mem u_alarm_comp (
    .i_clk_sys(i_clk_sys), .i_wr_en(wr_alarm), .i_wr_addr(wr_ptr), .i_wr_data(i_evt.component),
    .i_rd_addr(rd_addr), .o_rd_data(alarm_comp_q)
  );
  // per-slot kind, so the reader walks one shared chronology
  fdmb_hist_mem u_kind (
    .i_clk_sys(i_clk_sys), .i_wr_en(i_evt_valid), .i_wr_addr(wr_ptr),
    .i_wr_data({15'h0000, i_evt.is_alarm}), .i_rd_addr(rd_addr), .o_rd_data(kind_q)
  );

  // event write pointer wrapping and active counts saturating at the array depth
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_clear_active) begin
      wr_ptr <= '0;
      fault_cnt <= '0;
      alarm_cnt <= '0;
    end else if (i_evt_valid) begin
      wr_ptr <= wr_ptr + 1'b1;
      if (wr_fault && fault_cnt != (fdmb_pkg::HIST_AW+1)'(fdmb_pkg::HIST_DEPTH)) begin
        fault_cnt <= fault_cnt + 1'b1;
      end
      if (wr_alarm && alarm_cnt != (fdmb_pkg::HIST_AW+1)'(fdmb_pkg::HIST_DEPTH)) begin
        alarm_cnt <= alarm_cnt + 1'b1;
      end
    end
  end

  // active message classes; a new event wins over a clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      class_active <= '0;
    end else begin
      if (i_clear_active) begin
        class_active <= '0;
      end
      if (i_evt_valid && i_evt.msg_class < 5'(fdmb_pkg::NUM_CLASSES)) begin
        class_active[i_evt.msg_class] <= 1'b1;
      end
    end
  end

  // group diagnostics flag
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_group_diag <= 1'b0;
    end else begin
      o_group_diag <= any_active || i_evt_valid;
    end
  end

  // message sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      o_out_valid <= 1'b0;
      o_out <= '0;
      o_busy <= 1'b0;
      byte_idx <= '0;
      scan_cls <= '0;
      class_sent <= '0;
      rd_idx <= '0;
      rd_addr <= '0;
      fetch_wait <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          o_out_valid <= 1'b0;
          byte_idx <= '0;
          if (i_rd_start && i_rd_is_profinet) begin
            state <= ST_PN_SCAN;
            o_busy <= 1'b1;
            scan_cls <= '0;
            class_sent <= '0;
          end else if (i_rd_start && i_dpv1_mode) begin
            state <= ST_PB_STD;
            o_busy <= 1'b1;
          end
        end
        ST_PN_SCAN: begin
          // one 2-byte class code per active class, high byte first
          if (!o_out_valid || beat) begin
            if (o_out_valid && byte_idx == 3'd0) begin
              byte_idx <= 3'd1;
              o_out.data <= pn_class_code[7:0];
              o_out.last <= (class_active >> (scan_cls + 5'd1)) == '0;
            end else if (scan_cls == 5'(fdmb_pkg::NUM_CLASSES) || (o_out_valid && o_out.last)) begin
              o_out_valid <= 1'b0;
              o_busy <= 1'b0;
              state <= ST_IDLE;
            end else if (o_out_valid) begin
              o_out_valid <= 1'b0;
              byte_idx <= 3'd0;
              scan_cls <= scan_cls + 5'd1;
            end else if (class_active[scan_cls] && !class_sent[scan_cls]) begin
              class_sent[scan_cls] <= 1'b1;
              o_out_valid <= 1'b1;
              o_out.data <= pn_class_code[15:8];
              o_out.last <= 1'b0;
            end else begin
              scan_cls <= scan_cls + 5'd1;
            end
          end
        end
        ST_PB_STD: begin
          // six-byte standard block
          if (!o_out_valid || beat) begin
            o_out_valid <= 1'b1;
            o_out.last <= 1'b0;
            unique case (byte_idx)
              3'd0: o_out.data <= {4'h0, any_active, 3'b000};
              3'd3: o_out.data <= i_master_addr;
              default: o_out.data <= 8'h00;
            endcase
            if (byte_idx == 3'(fdmb_pkg::STD_DIAG_LEN - 8'd1)) begin
              byte_idx <= '0;
              state <= ST_PB_IDENT;
            end else begin
              byte_idx <= byte_idx + 3'd1;
            end
          end
        end
        ST_PB_IDENT: begin
          if (beat) begin
            o_out.data <= (byte_idx == 3'd0) ? {fdmb_pkg::HDR_IDENT, 6'(fdmb_pkg::IDENT_LEN)} :
                          {7'h00, any_active};
            if (byte_idx == 3'(fdmb_pkg::IDENT_LEN - 8'd1)) begin
              byte_idx <= '0;
              state <= ST_PB_MOD;
            end else begin
              byte_idx <= byte_idx + 3'd1;
            end
          end
        end
        ST_PB_MOD: begin
          if (beat) begin
            unique case (byte_idx)
              3'd0: o_out.data <= {fdmb_pkg::HDR_MODSTAT, mod_len[5:0]};
              3'd1: o_out.data <= fdmb_pkg::MODSTAT_CODE;
              default: o_out.data <= 8'h00;
            endcase
            if (byte_idx == 3'(mod_len - 8'd1)) begin
              byte_idx <= '0;
              rd_idx <= '0;
              rd_addr <= wr_ptr - 6'(fault_cnt + alarm_cnt);
              fetch_wait <= 1'b1;
              state <= ST_PB_FETCH;
            end else begin
              byte_idx <= byte_idx + 3'd1;
            end
          end
        end
        ST_PB_FETCH: begin
          // walk history oldest first, faults only, until the last byte drains
          if (beat) begin
            o_out_valid <= 1'b0;
          end
          if (!o_out_valid || beat) begin
            if (fetch_wait) begin
              fetch_wait <= 1'b0;
            end else if (rd_idx == (fault_cnt + alarm_cnt)) begin
              state <= ST_PB_ALARM;
            end else if (kind_q[0]) begin
              rd_idx <= rd_idx + 1'b1;
              rd_addr <= rd_addr + 1'b1;
              fetch_wait <= 1'b1;
            end else begin
              state <= ST_PB_CHAN;
            end
          end
        end
        ST_PB_CHAN: begin
          // three-byte channel block, no component assignment
          if (!o_out_valid || beat) begin
            o_out_valid <= 1'b1;
            o_out.last <= 1'b0;
            unique case (byte_idx)
              3'd0: o_out.data <= {fdmb_pkg::HDR_CHAN, 6'h00};
              3'd1: o_out.data <= 8'hc0;
              default: o_out.data <= {3'b000, fault_num_q[4:0]};
            endcase
            if (byte_idx == 3'(fdmb_pkg::CHAN_LEN - 8'd1)) begin
              byte_idx <= '0;
              rd_idx <= rd_idx + 1'b1;
              rd_addr <= rd_addr + 1'b1;
              fetch_wait <= 1'b1;
              state <= ST_PB_FETCH;
            end else begin
              byte_idx <= byte_idx + 3'd1;
            end
          end
        end
        ST_PB_ALARM: begin
          // closing diagnostics-alarm block with the slot state
          if (!o_out_valid || beat) begin
            if (o_out_valid && o_out.last) begin
              o_out_valid <= 1'b0;
              o_busy <= 1'b0;
              byte_idx <= '0;
              state <= ST_IDLE;
            end else begin
              o_out_valid <= 1'b1;
              unique case (byte_idx)
                3'd0: o_out.data <= fdmb_pkg::ALARM_LEN;
                3'd3: o_out.data <= {7'h00, any_active};
                default: o_out.data <= 8'h00;
              endcase
              o_out.last <= byte_idx == 3'(fdmb_pkg::ALARM_LEN - 8'd1);
              byte_idx <= byte_idx + 3'd1;
            end
          end
        end
      endcase
    end
  end
endmodule

// File: tb/fdmb_monitor.sv
// Purpose: port checks of the diagnostics message builder
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to fdmb_top below
`timescale 1ns/1ns
module fdmb_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // change requests
  input wire logic i_req_valid,
  input wire fdmb_pkg::fdmb_req_t i_req,
  input wire logic i_master_control_inhibit_input,
  input wire logic i_internal_calc_busy_indicator,
  input wire logic [7:0] i_commissioning_state_select,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_err,
  // events and stream
  input wire logic i_evt_valid,
  input wire logic i_rd_start,
  input wire logic i_rd_is_profinet,
  input wire logic i_dpv1_mode,
  input wire logic i_out_ready,
  input wire logic o_out_valid,
  input wire fdmb_pkg::fdmb_byte_t o_out,
  input wire logic o_busy,
  input wire logic o_group_diag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // request passes the higher-priority refusals
  wire logic s0 = i_req_valid && i_req.kind != fdmb_pkg::REQ_READ;
  wire logic s1 = i_req_valid && !i_req.download_active && !i_internal_calc_busy_indicator;
  wire logic s2 = s1 && !i_req.no_access_method && !i_req.know_how_protected;
  wire logic s3 = s2 && s0 && !i_req.access_code_missing;
  property p_dl;
    s0 && i_req.download_active |=> o_rsp_valid && o_rsp_err inside {8'h77, 8'h81};
  endproperty
  a_dl: assert property (p_dl) else $error("download answer wrong");
  property p_busy;
    s0 && !i_req.download_active && i_internal_calc_busy_indicator |=> o_rsp_err == 8'h84;
  endproperty
  a_busy: assert property (p_busy) else $error("busy answer wrong");
  property p_nam;
    s1 && i_req.no_access_method |=> o_rsp_err == 8'h85;
  endproperty
  a_nam: assert property (p_nam) else $error("access method answer wrong");
  property p_kh;
    s1 && !i_req.no_access_method && i_req.know_how_protected |=> o_rsp_err == 8'h87;
  endproperty
  a_kh: assert property (p_kh) else $error("protection answer wrong");
  property p_code;
    s2 && s0 && i_req.access_code_missing |=> o_rsp_err == 8'hcc;
  endproperty
  a_code: assert property (p_code) else $error("access code answer wrong");
  property p_inh;
    s3 && i_req.kind == fdmb_pkg::REQ_MASTER_CTRL && i_master_control_inhibit_input |=> o_rsp_err == 8'h82;
  endproperty
  a_inh: assert property (p_inh) else $error("takeover answer wrong");
  property p_flt;
    s3 && i_req.kind == fdmb_pkg::REQ_INTERCONNECT && !i_req.src_is_float && i_req.dst_needs_float
      |=> o_rsp_err == 8'h83;
  endproperty
  a_flt: assert property (p_flt) else $error("float answer wrong");
  property p_rec;
    s3 && i_req.kind == fdmb_pkg::REQ_DATA_RECORD_WR && i_commissioning_state_select != 8'h0f
      |=> o_rsp_err == 8'h86;
  endproperty
  a_rec: assert property (p_rec) else $error("record answer wrong");
  property p_low;
    s3 && i_req.kind == fdmb_pkg::REQ_PARAM_CHANGE && i_req.below_valid_limit |=> o_rsp_err == 8'hc8;
  endproperty
  a_low: assert property (p_low) else $error("lower limit answer wrong");
  property p_grp;
    i_evt_valid |=> o_group_diag;
  endproperty
  a_grp: assert property (p_grp) else $error("group flag not set");
  property p_hold;
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out.data) && $stable(o_out.last);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_end;
    o_out_valid && o_out.last && i_out_ready |=> !o_out_valid;
  endproperty
  a_end: assert property (p_end) else $error("byte after final");
  property p_dpv1;
    i_rd_start && !o_busy && !i_rd_is_profinet && !i_dpv1_mode |=> !o_busy [*3];
  endproperty
  a_dpv1: assert property (p_dpv1) else $error("read without dpv1");
  // main scenarios reached
  c_dl: cover property (i_req_valid && i_req.download_active);
  c_stall: cover property (o_out_valid && !i_out_ready);
  c_last: cover property (o_out_valid && o_out.last && i_out_ready);
endmodule
bind fdmb_top fdmb_monitor mon_u (.*);

// File: tb/fdmb_ctrl_model.sv
// Purpose: bus controller reading diagnostics bytes from the device
// Assumes: device clock, ready driven at the falling edge
// Notes: slow mode stalls at random; bytes are stamped on receipt
`timescale 1ns/1ns
module fdmb_ctrl_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // stream from the device
  input wire logic i_out_valid,
  input wire fdmb_pkg::fdmb_byte_t i_out,
  input wire logic i_slow,
  output logic o_ready
);
  int seed = 71922;
  logic [7:0] got[$];
  logic lst[$];
  time stamp[$];
  // sink readiness, random stalls when slow
  initial o_ready = 1'b0;
  always @(negedge i_clk_sys) o_ready <= !i_slow || 1'($random(seed));
  // record each byte with its arrival time
  always @(posedge i_clk_sys) begin
    if (!i_sys_rst && i_out_valid && o_ready) begin
      got.push_back(i_out.data);
      lst.push_back(i_out.last);
      stamp.push_back($time);
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench of the diagnostics message builder
// Assumes: 100 MHz clock, inputs driven at the falling edge
// Notes: seeded random change requests, directed message reads
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module testbench;
  logic i_clk_sys = 1'b0, i_sys_rst, i_req_valid, i_master_control_inhibit_input, i_internal_calc_busy_indicator;
  logic i_evt_valid, i_clear_active, i_rd_start, i_rd_is_profinet, i_dpv1_mode, i_cfg_object_lib;
  logic i_out_ready, o_rsp_valid, o_out_valid, o_busy, o_group_diag, slow;
  logic [7:0] i_commissioning_state_select, i_master_addr, o_rsp_err;
  fdmb_pkg::fdmb_req_t i_req;
  fdmb_pkg::fdmb_event_t i_evt;
  fdmb_pkg::fdmb_byte_t o_out;
  int seed = 71922;
  int num_errors = 0;
  int total_checks = 0;
  logic [19:0] acls;
  logic [7:0] fq[$], exp[$], msk[$];
  fdmb_top dut_u (.*);
  fdmb_ctrl_model ctl_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_out_valid(o_out_valid),
    .i_out(o_out), .i_slow(slow), .o_ready(i_out_ready));
  // clock
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // expected answer, highest refusal first; reads are no change
  function automatic logic [7:0] exp_err(fdmb_pkg::fdmb_req_t r, logic inh, logic bsy, logic [7:0] st);
    logic w = r.kind != fdmb_pkg::REQ_READ;
    if (w && r.download_active) return r.download_alt_code ? 8'h81 : 8'h77;
    if (w && bsy) return 8'h84;
    if (r.no_access_method) return 8'h85;
    if (r.know_how_protected) return 8'h87;
    if (!w) return 8'h00;
    if (r.access_code_missing) return 8'hcc;
    if (r.kind == fdmb_pkg::REQ_MASTER_CTRL && inh) return 8'h82;
    if (r.kind == fdmb_pkg::REQ_INTERCONNECT && !r.src_is_float && r.dst_needs_float) return 8'h83;
    if (r.kind == fdmb_pkg::REQ_DATA_RECORD_WR && st != 8'h0f) return 8'h86;
    if (r.below_valid_limit) return 8'hc8;
    if (r.above_valid_limit) return 8'hc9;
    return 8'h00;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic put(input logic [7:0] d, input logic [7:0] m);
    exp.push_back(d);
    msk.push_back(m);
  endtask
  // random requests, answer checked one cycle on
  task automatic req_burst(input int n);
    logic [7:0] pe;
    logic [8:0] f;
    logic [2:0] k;
    logic pv;
    pv = 0;
    pe = 0;
    for (int j = 0; j <= n; j++) begin
      @(negedge i_clk_sys);
      `CHK(o_rsp_valid, pv)
      if (pv) `CHK(o_rsp_err, pe)
      f = 9'($random(seed) & $random(seed));
      k = 3'(($random(seed) & 16'hffff) % 5);
      pv = (j < n) && (j % 7 != 6);
      i_req_valid = pv;
      i_req = fdmb_pkg::fdmb_req_t'({k, f});
      i_master_control_inhibit_input = 1'($random(seed));
      i_internal_calc_busy_indicator = ($random(seed) & 7) == 0;
      i_commissioning_state_select = 8'h0e + 8'($random(seed) & 1);
      pe = exp_err(i_req, i_master_control_inhibit_input, i_internal_calc_busy_indicator,
        i_commissioning_state_select);
    end
  endtask
  task automatic ev(input logic al, input logic [15:0] c, input logic [4:0] k);
    @(negedge i_clk_sys);
    i_evt_valid = 1;
    i_evt = '{al, c, c + 16'h1, k};
    if (!al) fq.push_back(c[7:0]);
    acls[k] = 1;
    @(negedge i_clk_sys);
    i_evt_valid = 0;
    `CHK(o_group_diag, 1'b1)
  endtask
  task automatic exp_pn();
    for (int c = 0; c < 20; c++) begin
      if (acls[c]) begin
        put(8'h90, 8'hff);
        put(8'(c), 8'hff);
      end
    end
  endtask
  // standard, identifier, module status, faults oldest first, alarm block
  task automatic exp_pb(input logic lib);
    i_master_addr = 8'($random(seed));
    for (int i = 0; i < 6; i++) put(i == 3 ? i_master_addr : 8'h08, i == 3 ? 8'hff : (i == 0 ? 8'h08 : 8'h00));
    put(8'h42, 8'hff);
    put(8'h01, 8'hff);
    put(lib ? 8'h06 : 8'h05, 8'hff);
    put(8'h82, 8'hff);
    for (int i = 0; i < (lib ? 4 : 3); i++) put(8'h00, 8'hff);
    foreach (fq[i]) begin
      put(8'h80, 8'hff);
      put(8'hc0, 8'hff);
      put(fq[i], 8'h1f);
    end
    for (int i = 0; i < 4; i++) put(i == 0 ? 8'h04 : 8'(i == 3), 8'hff);
  endtask
  task automatic rd(input logic pn, input logic lib, input logic dp);
    ctl_u.got.delete();
    ctl_u.lst.delete();
    @(negedge i_clk_sys);
    i_rd_start = 1;
    i_rd_is_profinet = pn;
    i_cfg_object_lib = lib;
    i_dpv1_mode = dp;
    @(negedge i_clk_sys);
    i_rd_start = 0;
    for (int t = 0; t < 600 && (o_busy || o_out_valid || t < 3); t++) @(negedge i_clk_sys);
    `CHK(o_busy, 1'b0)
    `CHK(ctl_u.got.size(), exp.size())
    foreach (exp[i]) begin
      if (i < ctl_u.got.size()) begin
        `CHK(ctl_u.got[i] & msk[i], exp[i] & msk[i])
        `CHK(ctl_u.lst[i], 1'(i == exp.size() - 1))
      end
    end
    exp.delete();
    msk.delete();
  endtask
  // main sequence
  initial begin
    {i_sys_rst, i_req_valid, i_master_control_inhibit_input, i_internal_calc_busy_indicator} = 4'h8;
    {i_evt_valid, i_clear_active, i_rd_start, i_rd_is_profinet, i_dpv1_mode, i_cfg_object_lib} = '0;
    {i_commissioning_state_select, i_master_addr, slow, acls, i_req, i_evt} = '0;
    repeat (4) @(negedge i_clk_sys);
    i_sys_rst = 0;
    `CHK(o_group_diag, 1'b0)
    req_burst(400);
    endt("requests");
    exp_pn();
    rd(1, 0, 1);
    ev(0, 16'h5, 5'd8);
    ev(1, 16'h7, 5'd3);
    ev(0, 16'h9, 5'd8);
    ev(0, 16'h2, 5'd19);
    exp_pn();
    rd(1, 0, 1);
    endt("class list");
    slow = 1;
    exp_pb(0);
    rd(0, 0, 1);
    slow = 0;
    exp_pb(1);
    rd(0, 1, 1);
    rd(0, 0, 0);
    endt("profibus");
    @(negedge i_clk_sys);
    i_clear_active = 1;
    @(negedge i_clk_sys);
    i_clear_active = 0;
    repeat (2) @(negedge i_clk_sys);
    `CHK(o_group_diag, 1'b0)
    acls = '0;
    exp_pn();
    rd(1, 0, 1);
    endt("clear");
    stop_test();
  end
endmodule
